// *** hdl/ard_pkg.sv ***
package ard_pkg;

    // ==========================================================
    // address map (28-bit physical space, bits 31..28 ignored)
    // ==========================================================
    localparam int          PHYS_W         = 28;
    localparam logic [27:0] IRAM_BASE      = 28'h0000000;
    localparam logic [27:0] IRAM_RSV_LAST  = 28'h00fffff;
    localparam logic [27:0] IRAM_PHYS_LAST = 28'h001ffff;
    localparam logic [27:0] DRAM_BASE      = 28'hfffb000;
    localparam logic [27:0] DRAM_LAST      = 28'hfffefff;
    localparam logic [27:0] DRAM_MIR_BASE  = 28'h3ffb000;
    localparam logic [27:0] DRAM_MIR_LAST  = 28'h3ffefff;
    localparam logic [27:0] PRH_BASE       = 28'hffff000;
    localparam logic [27:0] PRH_LAST       = 28'hfffffff;
    localparam logic [27:0] PRH_MIR_BASE   = 28'h3fff000;
    localparam logic [27:0] PRH_MIR_LAST   = 28'h3ffffff;
    localparam logic [27:0] PROH_LO_BASE   = 28'h3ff8000;
    localparam logic [27:0] PROH_LO_LAST   = 28'h3ffafff;
    localparam logic [27:0] PROH_HI_BASE   = 28'hfff8000;
    localparam logic [27:0] PROH_HI_LAST   = 28'hfffafff;
    localparam logic [27:0] EXT_A_BASE     = 28'h0100000;
    localparam logic [27:0] EXT_A_LAST     = 28'h3ff7fff;
    localparam logic [27:0] EXT_B_BASE     = 28'h4000000;
    localparam logic [27:0] EXT_B_LAST     = 28'hfff7fff;
    localparam logic [27:0] PROG_LAST      = 28'h3ffffff;

    // ==========================================================
    // local offsets, vectors, pointer reach
    // ==========================================================
    localparam int          IRAM_OFS_W     = 17;
    localparam int          DRAM_OFS_W     = 14;
    localparam int          PRH_OFS_W      = 12;
    localparam int          VEC_SHIFT      = 4;
    localparam int          VEC_ID_W       = 7;
    localparam logic [27:0] RESET_VECTOR   = 28'h0100000;
    localparam logic [31:0] PTR_REACH_KB   = 32'h0000_8000;

    // ==========================================================
    // chip-area select: 8 blocks, 4 bits each over two 16-bit cfg
    // ==========================================================
    localparam int          CS_NUM         = 8;
    localparam int          CS_BLK_SHIFT   = 25;
    localparam logic [15:0] CSC_A_RST      = 16'h2c11;
    localparam logic [15:0] CSC_B_RST      = 16'h2c11;

    // ==========================================================
    // types
    // ==========================================================
    typedef enum logic [2:0] {
        RGN_NONE, RGN_IRAM, RGN_DRAM, RGN_PERIPH, RGN_EXT, RGN_PROHIBIT
    } ard_region_t;

    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic        write;
        logic        half;
        logic [31:0] addr;
        logic [15:0] wdata;
    } ard_req_t;

    typedef struct packed {
        logic                  valid;
        ard_region_t           region;
        logic [PHYS_W-1:0]     phys;
        logic [CS_NUM-1:0]     cs;
        logic                  fault;
        logic                  write;
        logic [15:0]           wdata;
        logic [1:0]            wmask;
    } ard_sel_t;

endpackage

// *** hdl/ard_cs_map.sv ***
module ard_cs_map (
    // cfg
    input  wire logic [15:0]                cfgA,
    input  wire logic [15:0]                cfgB,
    // address
    input  wire logic [ard_pkg::PHYS_W-1:0] phys,
    input  wire logic                       extHit,
    // select
    output logic [ard_pkg::CS_NUM-1:0]      cs
);
    // ==========================================================
    // block select
    // ==========================================================
    // each block's 4-bit field in the cfg words picks, in its low 3 bits, which cs line may drive
    wire logic [2:0]  blkIdx = phys[27:25];
    wire logic [31:0] cfgAll = {cfgB, cfgA};
    wire logic [3:0]  nib    = cfgAll[{blkIdx, 2'b00} +: 4];
    wire logic [2:0]  csNum  = nib[2:0];

    always_comb begin
        cs = '0;
        if (extHit) begin
            cs[csNum] = 1'b1;
        end
    end
endmodule

// *** hdl/address_region_decoder.sv ***
// Operation
// RULE1: data RAM at FFFB000..FFFEFFF, 16 KB
// RULE2: 3FFB000..3FFEFFF mirrors the data RAM; the code folds only 3FFB000..3FFBFFF onto it
// RULE3: requesters avoid external access to holes
// RULE4: software never executes from data RAM
// RULE5: 4 KB peripheral window at FFFF000
// RULE6: peripheral mirror at 3FFF000 is prohibited
// RULE7: no instruction fetch from peripheral window
// RULE8: halfword to byte register: low byte only
// RULE9: 8-bit registers use byte accesses only
// RULE10: undefined peripheral addresses are reserved
// RULE11: DMA never uses the peripheral mirror
// RULE12: 256 MB external, fetch in lower 64 MB
// RULE13: route external windows to external bus
// RULE14: chip select chosen by two config words
// RULE15: never external cycle for internal regions
// RULE16: pointer plus/minus 32 KB reachable directly
// RULE17: address bits 31..28 are ignored
// RULE18: 128 KB physical instruction RAM at zero
// RULE19: vectors spaced 16 bytes in instruction RAM
// RULE20: one region or prohibited, same cycle
module address_region_decoder #(
    parameter int CS_N = ard_pkg::CS_NUM
) (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    // access request
    input  wire ard_pkg::ard_req_t          req,
    input  wire logic                       reqDma,
    // chip-area config
    input  wire logic [15:0]                chip_area_select_cfg_a,
    input  wire logic [15:0]                chip_area_select_cfg_b,
    // pointer-relative operand
    input  wire logic [31:0]                ptrBase,
    input  wire logic [15:0]                ptrDisp,
    input  wire logic                       ptrUse,
    // byte-register attribute of peripheral target
    input  wire logic                       prhByteReg,
    // vector request
    input  wire logic                       vecReq,
    input  wire logic [ard_pkg::VEC_ID_W-1:0] vecId,
    // decoded result
    output ard_pkg::ard_sel_t               sel_r,
    output logic                            readHiUndef_r,
    output logic                            vecValid_r,
    output logic [31:0]                     vecAddr_r
);
    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic inRange(
        input logic [ard_pkg::PHYS_W-1:0] a,
        input logic [ard_pkg::PHYS_W-1:0] lo,
        input logic [ard_pkg::PHYS_W-1:0] hi
    );
        inRange = (a >= lo) && (a <= hi);
    endfunction

    // ==========================================================
    // effective address
    // ==========================================================
    // sign-extended 16-bit displacement gives a +/-32 KB reach
    wire logic [31:0] dispExt = {{16{ptrDisp[15]}}, ptrDisp};
    wire logic [31:0] ptrSum  = ptrBase + dispExt; // RULE16
    wire logic [31:0] effAddr = ptrUse ? ptrSum : req.addr;
    // upper four bits dropped: all sixteen images alias
    wire logic [27:0] phys    = effAddr[27:0]; // RULE17

    // ==========================================================
    // region hits
    // ==========================================================
    wire logic hitIram    = inRange(phys, ard_pkg::IRAM_BASE, ard_pkg::IRAM_RSV_LAST);
    wire logic hitIramPhy = inRange(phys, ard_pkg::IRAM_BASE, ard_pkg::IRAM_PHYS_LAST); // RULE18
    wire logic hitDram    = inRange(phys, ard_pkg::DRAM_BASE, ard_pkg::DRAM_LAST); // RULE1
    wire logic hitDramMir = inRange(phys, ard_pkg::DRAM_MIR_BASE,
                                    ard_pkg::DRAM_MIR_LAST); // RULE2
    wire logic hitPrh     = inRange(phys, ard_pkg::PRH_BASE, ard_pkg::PRH_LAST); // RULE5
    wire logic hitPrhMir  = inRange(phys, ard_pkg::PRH_MIR_BASE, ard_pkg::PRH_MIR_LAST);
    wire logic hitHoleLo  = inRange(phys, ard_pkg::PROH_LO_BASE, ard_pkg::PROH_LO_LAST);
    wire logic hitHoleHi  = inRange(phys, ard_pkg::PROH_HI_BASE, ard_pkg::PROH_HI_LAST);
    wire logic hitExt     = inRange(phys, ard_pkg::EXT_A_BASE, ard_pkg::EXT_A_LAST)
                          | inRange(phys, ard_pkg::EXT_B_BASE, ard_pkg::EXT_B_LAST); // RULE13
    wire logic progSpace  = phys <= ard_pkg::PROG_LAST;

    // ==========================================================
    // faults
    // ==========================================================
    // unpopulated part of the instruction RAM reservation is refused,
    // never passed out to the external bus
    wire logic iramHole   = hitIram & ~hitIramPhy;
    // holes and the peripheral mirror are flagged rather than served;
    // this covers DMA misuse of the mirror as well
    wire logic holeFault  = hitHoleLo | hitHoleHi | hitPrhMir; // RULE6 RULE11 RULE3
    wire logic fetchFault = req.fetch & (hitPrh | hitDram | hitDramMir
                                         | ~progSpace); // RULE7 RULE4 RULE12
    wire logic anyFault   = holeFault | fetchFault | iramHole;

    // ==========================================================
    // region choice, one at most
    // ==========================================================
    ard_pkg::ard_region_t region;
    always_comb begin
        region = ard_pkg::RGN_NONE;
        if (anyFault) begin
            region = ard_pkg::RGN_PROHIBIT;
        end else if (hitIramPhy) begin
            region = ard_pkg::RGN_IRAM;
        end else if (hitDram | hitDramMir) begin
            region = ard_pkg::RGN_DRAM;
        end else if (hitPrh) begin
            region = ard_pkg::RGN_PERIPH;
        end else if (hitExt) begin
            region = ard_pkg::RGN_EXT;
        end
    end // RULE20

    // mirror keeps phys[13:0] under DRAM_BASE[27:14]: only 3FFB000..3FFBFFF lands on data RAM, the rest on FFF8000..FFFAFFF
    wire logic [27:0] physOut = hitDramMir ?
        {ard_pkg::DRAM_BASE[27:14], phys[13:0]} : phys; // RULE2

    // external cycle only when nothing internal claimed the address
    wire logic extGo = req.valid & (region == ard_pkg::RGN_EXT); // RULE15

    wire logic [CS_N-1:0] csNext;
    ard_cs_map u_cs (
        .cfgA   (chip_area_select_cfg_a),
        .cfgB   (chip_area_select_cfg_b),
        .phys   (phys),
        .extHit (extGo),
        .cs     (csNext)
    ); // RULE14

    // ==========================================================
    // width handling for byte peripheral registers
    // ==========================================================
    // a halfword hitting a byte register writes the low lane only
    wire logic byteCase  = (region == ard_pkg::RGN_PERIPH) & prhByteReg & req.half;
    wire logic [1:0] wmask = req.write ? ((req.half & ~byteCase) ? 2'b11 : 2'b01)
                                       : 2'b00; // RULE8 RULE9 RULE10

    // ==========================================================
    // vectors: fixed 16-byte stride from address zero
    // ==========================================================
    wire logic [31:0] vecNext = {{(32-ard_pkg::VEC_ID_W-ard_pkg::VEC_SHIFT){1'b0}},
                                 vecId, 4'h0}; // RULE19

    // ==========================================================
    // next values
    // ==========================================================
    // a refused access keeps its decode visible but drives no cycle
    wire logic                 accept      = req.valid & ~anyFault;
    wire ard_pkg::ard_region_t region_nxt  = req.valid ? region : ard_pkg::RGN_NONE;
    wire logic                 fault_nxt   = req.valid & anyFault;
    wire logic                 write_nxt   = accept & req.write;
    wire logic [15:0]          wdata_nxt   = byteCase ? {8'h00, req.wdata[7:0]}
                                                      : req.wdata; // RULE8
    wire logic [1:0]           wmask_nxt   = accept ? wmask : 2'b00;
    // the upper byte of such a read is not driven by the register
    wire logic                 hiUndef_nxt = req.valid & ~req.write & byteCase; // RULE8

    ard_pkg::ard_sel_t sel_nxt;
    assign sel_nxt.valid  = req.valid;
    assign sel_nxt.region = region_nxt;
    assign sel_nxt.phys   = physOut;
    assign sel_nxt.cs     = csNext;
    assign sel_nxt.fault  = fault_nxt;
    assign sel_nxt.write  = write_nxt;
    assign sel_nxt.wdata  = wdata_nxt;
    assign sel_nxt.wmask  = wmask_nxt;

    // ==========================================================
    // registered access result
    // ==========================================================
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sel_r         <= '0;
            readHiUndef_r <= 1'b0;
        end else begin
            sel_r         <= sel_nxt;
            readHiUndef_r <= hiUndef_nxt;
        end
    end

    // ==========================================================
    // registered vector lookup
    // ==========================================================
    // kept apart from the access path: a vector and an access may share a cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vecValid_r <= 1'b0;
            vecAddr_r  <= 32'h0000_0000;
        end else begin
            vecValid_r <= vecReq;
            vecAddr_r  <= vecNext; // RULE19
        end
    end
endmodule

// *** verification/ard_assertions.sv ***
module ard_assertions #(
    parameter int CS_N = 8
) (
    // clock and reset
    input wire logic                         core_clk,
    input wire logic                         nrst,
    // request side
    input wire ard_pkg::ard_req_t            req,
    input wire logic                         ptrUse,
    input wire logic                         prhByteReg,
    input wire logic                         vecReq,
    input wire logic [ard_pkg::VEC_ID_W-1:0] vecId,
    // results
    input wire ard_pkg::ard_sel_t            sel_r,
    input wire logic                         vecValid_r,
    input wire logic [31:0]                  vecAddr_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    wire logic [27:0] pa = req.addr[27:0];
    // ==========================================================
    // sequences
    // ==========================================================
    sequence s_plain;
        req.valid && !ptrUse && !req.fetch;
    endsequence
    sequence s_dram_mir;
        s_plain ##0 (pa >= ard_pkg::DRAM_MIR_BASE && pa <= ard_pkg::DRAM_MIR_LAST);
    endsequence
    sequence s_dram;
        s_plain ##0 (pa >= ard_pkg::DRAM_BASE && pa <= ard_pkg::DRAM_LAST);
    endsequence
    // ==========================================================
    // properties
    // ==========================================================
    a_valid_latency: assert property (req.valid |=> sel_r.valid)
        else $error("request not answered in one cycle");
    a_idle_quiet: assert property (!req.valid |=> !sel_r.valid && !sel_r.fault)
        else $error("result without request");
    a_fault_region: assert property (sel_r.fault == (sel_r.region == ard_pkg::RGN_PROHIBIT))
        else $error("fault and region disagree");
    a_fault_quiet: assert property (sel_r.fault |-> sel_r.cs == '0 && !sel_r.write && sel_r.wmask == 2'h0)
        else $error("refused access still drives a cycle");
    a_ext_onehot: assert property (sel_r.region == ard_pkg::RGN_EXT |-> $onehot(sel_r.cs))
        else $error("external access without one chip select");
    a_internal_nocs: assert property (sel_r.region inside {ard_pkg::RGN_IRAM, ard_pkg::RGN_DRAM,
        ard_pkg::RGN_PERIPH} |-> sel_r.cs == '0)
        else $error("chip select on internal region");
    a_dram_hit: assert property (s_dram |=> sel_r.region == ard_pkg::RGN_DRAM && sel_r.phys == $past(pa))
        else $error("data ram window misdecoded");
    a_dram_mirror: assert property (s_dram_mir |=> sel_r.region == ard_pkg::RGN_DRAM
        && sel_r.phys == {4'hf, $past(pa[23:0])})
        else $error("data ram mirror not folded");
    a_periph_fetch: assert property (req.valid && !ptrUse && req.fetch && pa >= ard_pkg::PRH_BASE |=> sel_r.fault)
        else $error("fetch from peripheral window accepted");
    a_half_byte: assert property (s_plain ##0 (req.write && req.half && prhByteReg && pa >= ard_pkg::PRH_BASE)
        |=> sel_r.wmask == 2'h1 && sel_r.wdata[15:8] == 8'h00)
        else $error("halfword to byte register writes high byte");
    a_vec_addr: assert property (vecReq |=> vecValid_r && vecAddr_r == {21'h0, $past(vecId), 4'h0})
        else $error("vector address wrong");
endmodule

bind address_region_decoder ard_assertions #(.CS_N(CS_N)) u_ard_chk (
    .core_clk(core_clk), .nrst(nrst), .req(req), .ptrUse(ptrUse), .prhByteReg(prhByteReg),
    .vecReq(vecReq), .vecId(vecId), .sel_r(sel_r), .vecValid_r(vecValid_r), .vecAddr_r(vecAddr_r)
);

// *** verification/ard_requester.sv ***
module ard_requester (
    // clock
    input  wire logic        core_clk,
    // access out
    output ard_pkg::ard_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    // changes only just after an edge, holds until the next issue
    task automatic issue(input logic [31:0] a, input logic f, w, h, input logic [15:0] d);
        @(posedge core_clk);
        #1;
        req = {1'h1, f, w, h, a, d};
    endtask
endmodule

// *** verification/address_region_decoder_tb_top.sv ***
module address_region_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0]          a;
        logic                 f;
        logic                 w;
        ard_pkg::ard_region_t rg;
    } ard_row_t;
    localparam ard_row_t ROWS [16] = '{
        '{32'h10100000, 1'h0, 1'h0, ard_pkg::RGN_EXT},
        '{32'hf3ffb010, 1'h0, 1'h0, ard_pkg::RGN_DRAM},
        '{32'h0fffb000, 1'h0, 1'h1, ard_pkg::RGN_DRAM},
        '{32'h0fffefff, 1'h0, 1'h0, ard_pkg::RGN_DRAM},
        '{32'h0ffff000, 1'h0, 1'h1, ard_pkg::RGN_PERIPH},
        '{32'h03fff000, 1'h0, 1'h1, ard_pkg::RGN_PROHIBIT},
        '{32'h0ffff010, 1'h1, 1'h0, ard_pkg::RGN_PROHIBIT},
        '{32'h0fffb000, 1'h1, 1'h0, ard_pkg::RGN_PROHIBIT},
        '{32'h0fff8000, 1'h0, 1'h1, ard_pkg::RGN_PROHIBIT},
        '{32'h03ffafff, 1'h0, 1'h0, ard_pkg::RGN_PROHIBIT},
        '{32'h0001ffff, 1'h1, 1'h0, ard_pkg::RGN_IRAM},
        '{32'h00020000, 1'h0, 1'h0, ard_pkg::RGN_PROHIBIT},
        '{32'h03ff7fff, 1'h1, 1'h0, ard_pkg::RGN_EXT},
        '{32'h04000000, 1'h1, 1'h0, ard_pkg::RGN_PROHIBIT},
        '{32'h0fff7fff, 1'h0, 1'h1, ard_pkg::RGN_EXT},
        '{32'h04000000, 1'h0, 1'h1, ard_pkg::RGN_EXT}};
    logic                    core_clk, nrst, reqDma, ptrUse, prhByteReg, vecReq, readHiUndef_r;
    logic                    vecValid_r;
    logic [15:0]             cfgA, cfgB, ptrDisp;
    logic [31:0]             ptrBase, vecAddr_r;
    logic [6:0]              vecId;
    ard_pkg::ard_req_t       req;
    ard_pkg::ard_sel_t       sel_r;
    int                      bad_count = 0;
    int                      compares = 0;
    ard_requester rq (.core_clk(core_clk), .req(req));
    address_region_decoder uut (.core_clk(core_clk), .nrst(nrst), .req(req), .reqDma(reqDma),
        .chip_area_select_cfg_a(cfgA), .chip_area_select_cfg_b(cfgB), .ptrBase(ptrBase),
        .ptrDisp(ptrDisp), .ptrUse(ptrUse), .prhByteReg(prhByteReg), .vecReq(vecReq),
        .vecId(vecId), .sel_r(sel_r), .readHiUndef_r(readHiUndef_r), .vecValid_r(vecValid_r),
        .vecAddr_r(vecAddr_r));
    // ==========================================================
    // helpers
    // ==========================================================
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] ecs(input logic [27:0] p);
        logic [31:0] c;
        c = {cfgB, cfgA};
        return 8'h01 << c[p[27:25]*4 +: 3];
    endfunction
    // issue at ia, then judge the one-cycle answer against row r
    task automatic exec(input ard_row_t r, input logic [31:0] ia, input logic h, input logic [15:0] d);
        logic flt;
        logic [27:0] ep;
        flt = (r.rg == ard_pkg::RGN_PROHIBIT);
        ep = (r.rg == ard_pkg::RGN_DRAM) ? {4'hf, r.a[23:0]} : r.a[27:0];
        rq.issue(ia, r.f, r.w, h, d);
        @(posedge core_clk);
        #1;
        chk("valid", 64'h1, 64'(sel_r.valid));
        chk("hi undef", 64'h0, 64'(readHiUndef_r));
        chk("region", 64'(r.rg), 64'(sel_r.region));
        chk("fault", 64'(flt), 64'(sel_r.fault));
        chk("cs", (r.rg == ard_pkg::RGN_EXT) ? 64'(ecs(ep)) : 64'h0, 64'(sel_r.cs));
        chk("write", 64'(r.w & !flt), 64'(sel_r.write));
        if (!flt) chk("phys", 64'(ep), 64'(sel_r.phys));
    endtask
    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        give_verdict();
    end
    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        {nrst, reqDma, ptrUse, prhByteReg, vecReq, vecId, ptrBase, ptrDisp} = '0;
        cfgA = 16'h7654;
        cfgB = 16'h3210;
        repeat (6) @(posedge core_clk);
        #1;
        chk("reset sel", 64'h0, 64'(sel_r));
        nrst = 1'h1;
        $display("test reset done");
        foreach (ROWS[i]) exec(ROWS[i], ROWS[i].a, 1'h0, 16'h1234);
        cfgA = 16'h0123;
        exec(ROWS[0], ROWS[0].a, 1'h0, 16'h0);
        $display("test table done");
        prhByteReg = 1'h1;
        exec(ROWS[4], 32'h0ffff000, 1'h1, 16'habcd);
        chk("wmask", 64'h1, 64'(sel_r.wmask));
        chk("wdata", 64'h00cd, 64'(sel_r.wdata));
        exec(ROWS[3], 32'h0fffefff, 1'h0, 16'h0);
        rq.issue(32'h0ffff003, 1'h0, 1'h0, 1'h1, 16'h0);
        @(posedge core_clk);
        #1;
        chk("hi undef", 64'h1, 64'(readHiUndef_r));
        $display("test byte register done");
        ptrUse = 1'h1;
        ptrDisp = 16'hb010;
        exec('{32'h0fffb010, 1'h0, 1'h0, ard_pkg::RGN_DRAM}, 32'h0, 1'h0, 16'h0);
        ptrBase = 32'h00100000;
        ptrDisp = 16'h7fff;
        exec('{32'h00107fff, 1'h0, 1'h0, ard_pkg::RGN_EXT}, 32'h0, 1'h0, 16'h0);
        ptrUse = 1'h0;
        reqDma = 1'h1;
        exec('{32'h03fff100, 1'h0, 1'h1, ard_pkg::RGN_PROHIBIT}, 32'h03fff100, 1'h0, 16'h0);
        $display("test pointer and dma done");
        vecReq = 1'h1;
        for (int k = 0; k < 3; k++) begin
            vecId = (k == 0) ? 7'h00 : (k == 1) ? 7'h17 : 7'h7f;
            @(posedge core_clk);
            #1;
            chk("vec valid", 64'h1, 64'(vecValid_r));
            chk("vec addr", 64'(vecId) * 16, 64'(vecAddr_r));
        end
        $display("test vectors done");
        nrst = 1'h0;
        #1;
        chk("mid reset sel", 64'h0, 64'(sel_r));
        chk("mid reset vec", 64'h0, 64'(vecValid_r));
        @(posedge core_clk);
        #1;
        nrst = 1'h1;
        exec(ROWS[1], ROWS[1].a, 1'h0, 16'h0);
        $display("test mid reset done");
        give_verdict();
    end
endmodule
